// ### shared/odc_pkg.sv
// constants and types for the output driver control and status block
// Functional notes
// - internal resistor: voltage range codes decoded
// - internal resistor: current range codes decoded
// - clear select picks zero or midscale
// - outputs disabled unless enable bit set in software mode, enable pin in pin mode
// - resistor select joins range code
// - reset bit restores power-on state
// - read needs matching address and read bit
// - data out tristate; drives from fifth edge
// - frame sync rise tristates data out
// - readback word field layout
// - control and status in one read
// - status read-only; any sets fault low in software mode
// - crc failure sets interface error bit
// - overtemperature sets its status bit
// - current loop open sets its bit
// - voltage short sets its bit
// - strap high: range from pins
// - pin mode: three separate fault pins
// - status read clears interface error flag
// - 24-bit frame crc checked before write
// - clear level is pin OR bit in software mode, pin alone in pin mode
package odc_pkg;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int FRAME_BITS_CRC = 24;
  localparam logic [4:0] HDR_BITS = 5'h04;
  localparam logic [4:0] RD_DONE_BITS = 5'h14;
  localparam logic [4:0] FRAME_CNT = 5'h10;
  localparam logic [4:0] FRAME_CNT_CRC = 5'h18;

  // ----------------------------------------------------------------
  // write and readback word fields
  // ----------------------------------------------------------------
  localparam int POS_ADDR_LO = 13;
  localparam int POS_RW = 12;
  localparam int POS_ZERO = 11;
  localparam int POS_RANGE_LO = 7;
  localparam int POS_CLEAR_LEVEL_SELECT = 6;
  localparam int POS_OUTPUT_ENABLE_BIT = 5;
  localparam int POS_SENSE_RESISTOR_SELECT = 4;
  localparam int POS_CLEAR = 3;
  localparam int POS_RESET = 2;
  localparam logic [1:0] RB_MARK = 2'h2;

  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  localparam int STAT_CRC = 3;
  localparam int STAT_TEMP = 2;
  localparam int STAT_OPEN = 1;
  localparam int STAT_SHORT = 0;

  // ----------------------------------------------------------------
  // reset values and crc
  // ----------------------------------------------------------------
  localparam logic [3:0] RANGE_RST = 4'h0;
  localparam logic CLEAR_LEVEL_SELECT_RST = 1'b0;
  localparam logic OUTPUT_ENABLE_BIT_RST = 1'b0;
  localparam logic SENSE_RESISTOR_SELECT_RST = 1'b0;
  localparam logic CLEAR_RST = 1'b0;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // ----------------------------------------------------------------
  // decoded output range
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ODC_OFF = 4'b0000,
    ODC_I_4_20 = 4'b0001,
    ODC_I_0_20 = 4'b0010,
    ODC_I_0_24 = 4'b0011,
    ODC_V_0_5 = 4'b0100,
    ODC_V_0_10 = 4'b0101,
    ODC_V_0_6 = 4'b0110,
    ODC_V_0_12 = 4'b0111,
    ODC_V_0_40 = 4'b1000,
    ODC_V_0_44 = 4'b1001,
    ODC_I_392_204 = 4'b1010,
    ODC_I_0_204 = 4'b1011,
    ODC_I_0_245 = 4'b1100
  } odc_range_t;

endpackage

// ### rtl/odc_crc8.sv
// serial crc-8 engine, one message bit per enable
`timescale 1ns/100ps
module odc_crc8
  import odc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic en,
  input wire logic din,
  output logic [7:0] crc
);

  logic [7:0] crc_r;
  logic [7:0] crc_nxt;
  logic fb;

  // ----------------------------------------------------------------
  // msb-first shift with polynomial feedback
  // ----------------------------------------------------------------
  assign fb = crc_r[7] ^ din;
  assign crc_nxt = {crc_r[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
  assign crc = crc_r;

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      crc_r <= CRC_INIT;
    end else if (en) begin
      crc_r <= crc_nxt;
    end
  end

endmodule

// ### rtl/odc_ctrl.sv
// serial control, range decode, readback and fault reporting
`timescale 1ns/100ps
module odc_ctrl
  import odc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic [2:0] device_address,
  input wire logic control_source_select,
  input wire logic [3:0] range_pins,
  input wire logic sense_resistor_pin,
  input wire logic clear_level_pin,
  input wire logic clear_pin,
  input wire logic output_enable_pin,
  input wire logic over_temp,
  input wire logic loop_open,
  input wire logic volt_short,
  output logic fault_o,
  output logic fault_oe,
  output logic current_loop_fault_n_o,
  output logic current_loop_fault_n_oe,
  output logic voltage_short_fault_n_o,
  output logic voltage_short_fault_n_oe,
  output logic over_temp_fault_n_o,
  output logic over_temp_fault_n_oe,
  output odc_range_t range_sel,
  output logic current_mode,
  output logic range_valid,
  output logic outputs_enabled,
  output logic clear_active,
  output logic clear_to_mid
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 18;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  logic sclk_d_r;
  logic syncn_d_r;

  assign async_in = {sclk, sync_n, sdi, device_address,
                     control_source_select, range_pins,
                     sense_resistor_pin, clear_level_pin, clear_pin,
                     output_enable_pin, over_temp, loop_open, volt_short};

  // unreset: pins flush through while rst is held, no false frame edge
  always_ff @(posedge clk) begin
    meta_r <= async_in;
    sync_r <= meta_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_d_r <= 1'b0;
      syncn_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sync_r[17];
      syncn_d_r <= sync_r[16];
    end
  end

  logic s_sclk;
  logic s_syncn;
  logic s_sdi;
  logic [2:0] s_addr;
  logic s_hw;
  logic [3:0] s_rpin;
  logic s_rsetpin;
  logic s_clrselpin;
  logic s_clearpin;
  logic s_outenpin;
  logic s_temp;
  logic s_open;
  logic s_short;

  assign s_sclk = sync_r[17];
  assign s_syncn = sync_r[16];
  assign s_sdi = sync_r[15];
  assign s_addr = sync_r[14:12];
  assign s_hw = sync_r[11];
  assign s_rpin = sync_r[10:7];
  assign s_rsetpin = sync_r[6];
  assign s_clrselpin = sync_r[5];
  assign s_clearpin = sync_r[4];
  assign s_outenpin = sync_r[3];
  assign s_temp = sync_r[2];
  assign s_open = sync_r[1];
  assign s_short = sync_r[0];

  // ----------------------------------------------------------------
  // frame events
  // ----------------------------------------------------------------
  logic sclk_rise;
  logic frame_on;
  logic frame_end;
  logic bit_take;

  assign sclk_rise = s_sclk & ~sclk_d_r;
  assign frame_on = ~s_syncn;
  assign frame_end = s_syncn & ~syncn_d_r;
  assign bit_take = sclk_rise & frame_on;

  logic [23:0] shift_r;
  logic [4:0] cnt_r;
  logic [7:0] crc_calc;
  logic crc_en;

  assign crc_en = bit_take && (cnt_r < FRAME_CNT);

  odc_crc8 i_odc_crc8 (
    .clk(clk),
    .rst(rst),
    .clr(frame_end),
    .en(crc_en),
    .din(s_sdi),
    .crc(crc_calc)
  );

  always_ff @(posedge clk) begin
    if (rst || frame_end) begin
      shift_r <= '0;
      cnt_r <= '0;
    end else if (bit_take) begin
      shift_r <= {shift_r[22:0], s_sdi};
      cnt_r <= (cnt_r == FRAME_CNT_CRC) ? cnt_r : cnt_r + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  logic [15:0] word16;
  logic [15:0] word24;
  logic [7:0] crc_rx;
  logic len16;
  logic len24;
  logic [15:0] wr_word;
  logic addr_ok;
  logic crc_good;
  logic wr_go;
  logic crc_fail;
  logic soft_reset;

  assign word16 = shift_r[15:0];
  assign word24 = shift_r[23:8];
  assign crc_rx = shift_r[7:0];
  assign len16 = (cnt_r == FRAME_CNT);
  assign len24 = (cnt_r == FRAME_CNT_CRC);
  assign wr_word = len24 ? word24 : word16;
  assign addr_ok = (wr_word[15:POS_ADDR_LO] == s_addr) &&
                   !wr_word[POS_RW];
  assign crc_good = (crc_rx == crc_calc);
  assign wr_go = frame_end && !s_hw && addr_ok &&
                 (len16 || (len24 && crc_good));
  assign crc_fail = frame_end && !s_hw && len24 && !crc_good;
  assign soft_reset = wr_go && wr_word[POS_RESET];

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [3:0] range_r;
  logic clear_level_select_r;
  logic output_enable_bit_r;
  logic sense_resistor_select_r;
  logic swclr_r;

  always_ff @(posedge clk) begin
    if (rst || soft_reset) begin
      range_r <= RANGE_RST;
      clear_level_select_r <= CLEAR_LEVEL_SELECT_RST;
      output_enable_bit_r <= OUTPUT_ENABLE_BIT_RST;
      sense_resistor_select_r <= SENSE_RESISTOR_SELECT_RST;
      swclr_r <= CLEAR_RST;
    end else if (wr_go) begin
      range_r <= wr_word[POS_RANGE_LO+3:POS_RANGE_LO];
      clear_level_select_r <= wr_word[POS_CLEAR_LEVEL_SELECT];
      output_enable_bit_r <= wr_word[POS_OUTPUT_ENABLE_BIT];
      sense_resistor_select_r <= wr_word[POS_SENSE_RESISTOR_SELECT];
      swclr_r <= wr_word[POS_CLEAR];
    end
  end

  // ----------------------------------------------------------------
  // status and readback
  // ----------------------------------------------------------------
  logic crc_err_r;
  logic [3:0] status;
  logic rd_hit;
  logic rd_act_r;
  logic rd_done;
  logic [15:0] tx_r;
  logic [15:0] rb_word;
  logic sdo_r;
  logic sdo_oe_r;

  // live fault levels, sticky interface error
  assign status = {crc_err_r, s_temp, s_open, s_short};
  assign rb_word = {s_addr, RB_MARK, range_r, clear_level_select_r, output_enable_bit_r,
                    sense_resistor_select_r, status};
  assign rd_hit = bit_take && !s_hw && (cnt_r == HDR_BITS) &&
                  (shift_r[3:1] == s_addr) && shift_r[0];
  assign rd_done = frame_end && rd_act_r && (cnt_r >= RD_DONE_BITS);

  always_ff @(posedge clk) begin
    if (rst || soft_reset) begin
      crc_err_r <= 1'b0;
    end else if (crc_fail) begin // set wins over clear
      crc_err_r <= 1'b1;
    end else if (rd_done) begin
      crc_err_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || frame_end) begin
      rd_act_r <= 1'b0;
      tx_r <= '0;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else if (rd_hit) begin // fifth rising edge
      rd_act_r <= 1'b1;
      tx_r <= {rb_word[14:0], 1'b0};
      sdo_r <= rb_word[15];
      sdo_oe_r <= 1'b1;
    end else if (bit_take && rd_act_r) begin
      tx_r <= {tx_r[14:0], 1'b0};
      sdo_r <= tx_r[15];
    end
  end

  assign sdo_o = sdo_r;
  assign sdo_oe = sdo_oe_r;

  // ----------------------------------------------------------------
  // range decode
  // ----------------------------------------------------------------
  function automatic odc_range_t decode(input logic rs,
                                        input logic [3:0] rc);
    odc_range_t v;
    v = ODC_OFF;
    unique case (rc)
      4'h0: v = ODC_I_4_20;
      4'h1: v = ODC_I_0_20;
      4'h2: v = ODC_I_0_24;
      4'h5: v = ODC_V_0_5;
      4'h6: v = ODC_V_0_10;
      4'h9: v = ODC_V_0_6;
      4'ha: v = ODC_V_0_12;
      4'hd: v = rs ? ODC_I_392_204 : ODC_OFF;
      4'he: v = rs ? ODC_I_0_204 : ODC_V_0_40;
      4'hf: v = rs ? ODC_I_0_245 : ODC_V_0_44;
      default: v = ODC_OFF; // unused codes
    endcase
    return v;
  endfunction

  logic eff_sense_resistor_select;
  logic [3:0] eff_range;
  logic eff_output_enable_bit;
  odc_range_t dec;
  logic dec_cur;

  assign eff_sense_resistor_select = s_hw ? s_rsetpin : sense_resistor_select_r;
  assign eff_range = s_hw ? s_rpin : range_r;
  assign eff_output_enable_bit = s_hw ? s_outenpin : output_enable_bit_r;
  assign dec = decode(eff_sense_resistor_select, eff_range);
  assign dec_cur = (dec == ODC_I_4_20) || (dec == ODC_I_0_20) ||
                   (dec == ODC_I_0_24) || (dec == ODC_I_392_204) ||
                   (dec == ODC_I_0_204) || (dec == ODC_I_0_245);

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  odc_range_t range_sel_r;
  logic cur_r;
  logic valid_r;
  logic output_enable_bit_out_r;
  logic clr_act_r;
  logic clr_mid_r;
  logic fault_r;
  logic current_loop_fault_n_r;
  logic voltage_short_fault_n_r;
  logic tfault_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      range_sel_r <= ODC_OFF;
      cur_r <= 1'b0;
      valid_r <= 1'b0;
      output_enable_bit_out_r <= 1'b0;
      clr_act_r <= 1'b0;
      clr_mid_r <= 1'b0;
      fault_r <= 1'b0;
      current_loop_fault_n_r <= 1'b0;
      voltage_short_fault_n_r <= 1'b0;
      tfault_r <= 1'b0;
    end else begin
      range_sel_r <= dec;
      cur_r <= dec_cur;
      valid_r <= (dec != ODC_OFF);
      output_enable_bit_out_r <= eff_output_enable_bit;
      clr_act_r <= s_clearpin | (!s_hw & swclr_r);
      clr_mid_r <= s_clrselpin | (!s_hw & clear_level_select_r);
      fault_r <= !s_hw && (|status);
      current_loop_fault_n_r <= s_hw && s_open;
      voltage_short_fault_n_r <= s_hw && s_short;
      tfault_r <= s_hw && s_temp;
    end
  end

  assign range_sel = range_sel_r;
  assign current_mode = cur_r;
  assign range_valid = valid_r;
  assign outputs_enabled = output_enable_bit_out_r;
  assign clear_active = clr_act_r;
  assign clear_to_mid = clr_mid_r;
  assign fault_o = 1'b0;
  assign fault_oe = fault_r;
  assign current_loop_fault_n_o = 1'b0;
  assign current_loop_fault_n_oe = current_loop_fault_n_r;
  assign voltage_short_fault_n_o = 1'b0;
  assign voltage_short_fault_n_oe = voltage_short_fault_n_r;
  assign over_temp_fault_n_o = 1'b0;
  assign over_temp_fault_n_oe = tfault_r;

endmodule

// ### test/odc_host.sv
// host model: frames on the serial link, readback capture
`timescale 1ns/100ps
module odc_host (
  input wire logic clk,
  output logic sclk,
  output logic sync_n,
  output logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  logic last = 1'b0;
  logic line;
  // released data line shows the inverse of its last bit
  assign line = sdo_oe ? sdo_o : ~last;
  always @(posedge clk) if (sdo_oe) last <= sdo_o;
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
  end
  // whole frame, msb first; sclk stands low between frames
  task xfer(input int n, input logic [23:0] w, output logic [15:0] rd,
    output logic seen);
    rd = 16'h0000;
    seen = 1'b0;
    @(posedge clk);
    sync_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i <= n; i++) begin
      if (i < n) sdi <= w[23-i];
      repeat (3) @(posedge clk);
      @(negedge clk);
      if (i >= 5 && i <= 20) begin
        rd[20-i] = line;
        seen = seen | sdo_oe;
      end
      @(posedge clk);
      if (i < n) begin
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        sclk <= 1'b0;
      end
    end
    sync_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
endmodule

// ### test/odc_ctrl_properties.sv
// assertions on the ports of the control block
`timescale 1ns/100ps
module odc_ctrl_properties
  import odc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_n,
  input wire logic sdo_oe,
  input wire logic control_source_select,
  input wire logic [3:0] range_pins,
  input wire logic sense_resistor_pin,
  input wire logic clear_level_pin,
  input wire logic clear_pin,
  input wire logic over_temp,
  input wire logic loop_open,
  input wire logic volt_short,
  input wire logic fault_o,
  input wire logic fault_oe,
  input wire logic current_loop_fault_n_o,
  input wire logic current_loop_fault_n_oe,
  input wire logic over_temp_fault_n_oe,
  input odc_range_t range_sel,
  input wire logic current_mode,
  input wire logic range_valid,
  input wire logic clear_active,
  input wire logic clear_to_mid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sdo_idle_a: assert property (sync_n [*6] |-> !sdo_oe)
    else $error("data out driven outside a frame");
  sw_fault_a: assert property (
    (volt_short && !control_source_select) [*5] |-> fault_oe && !fault_o)
    else $error("shared fault not pulled low");
  hw_open_a: assert property (
    (loop_open && control_source_select) [*5]
    |-> current_loop_fault_n_oe && !current_loop_fault_n_o)
    else $error("loop fault pin not low");
  hw_temp_a: assert property (
    (!over_temp && control_source_select) [*5] |-> !over_temp_fault_n_oe)
    else $error("temperature pin low without fault");
  hw_nosdo_a: assert property (
    control_source_select [*8] |-> !sdo_oe)
    else $error("data out driven in pin mode");
  hw_range_a: assert property (
    (control_source_select && sense_resistor_pin && range_pins == 4'h5) [*5]
    |-> range_sel == ODC_V_0_5)
    else $error("pin range not decoded");
  valid_a: assert property (range_valid == (range_sel != ODC_OFF))
    else $error("range valid mismatch");
  cur_mode_a: assert property (
    current_mode == (range_sel inside {ODC_I_4_20, ODC_I_0_20, ODC_I_0_24,
    ODC_I_392_204, ODC_I_0_204, ODC_I_0_245}))
    else $error("current mode mismatch");
  clr_pin_a: assert property (clear_pin [*5] |-> clear_active)
    else $error("clear pin not in force");
  clr_lvl_a: assert property (clear_level_pin [*5] |-> clear_to_mid)
    else $error("clear level pin ignored");
  cover property (fault_oe);
  cover property ($fell(sdo_oe));
  cover property (clear_active && clear_to_mid);
endmodule
bind odc_ctrl odc_ctrl_properties i_odc_ctrl_properties (.clk, .rst,
  .sync_n, .sdo_oe, .control_source_select, .range_pins,
  .sense_resistor_pin, .clear_level_pin, .clear_pin, .over_temp, .loop_open,
  .volt_short, .fault_o, .fault_oe, .current_loop_fault_n_o,
  .current_loop_fault_n_oe, .over_temp_fault_n_oe, .range_sel,
  .current_mode, .range_valid, .clear_active, .clear_to_mid);

// ### test/tb_odc_ctrl.sv
// testbench for the output driver control block
`timescale 1ns/100ps
module tb_odc_ctrl;
  import odc_pkg::*;
  localparam logic [2:0] ADDR = 3'h5;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, sync_n, sdi, sdo_o, sdo_oe, seen;
  logic hw = 1'b0, sense_resistor_select_p = 1'b0, clrlvl = 1'b0, clrp = 1'b0;
  logic oenp = 1'b0;
  logic vs_oe, rvalid;
  logic otemp = 1'b0, lopen = 1'b0, vshort = 1'b0;
  logic [3:0] rpins = 4'h0;
  logic fault_oe, cl_oe, ot_oe, cmode, output_enable_bit, clr_act, clr_mid;
  logic [15:0] rd;
  odc_range_t rsel;
  int bad_count = 0;
  int tests_run = 0;
  logic [3:0] codes [7] = '{4'h5, 4'h6, 4'h9, 4'ha, 4'hd, 4'he, 4'hf};
  odc_range_t exp_r [7] = '{ODC_V_0_5, ODC_V_0_10, ODC_V_0_6, ODC_V_0_12,
    ODC_I_392_204, ODC_I_0_204, ODC_I_0_245};
  always #20 clk = ~clk;
  odc_host i_odc_host (.clk(clk), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe));
  odc_ctrl i_odc_ctrl (.clk(clk), .rst(rst), .sclk(sclk), .sync_n(sync_n),
    .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .device_address(ADDR),
    .control_source_select(hw), .range_pins(rpins),
    .sense_resistor_pin(sense_resistor_select_p), .clear_level_pin(clrlvl),
    .clear_pin(clrp), .output_enable_pin(oenp), .over_temp(otemp),
    .loop_open(lopen), .volt_short(vshort), .fault_o(), .fault_oe(fault_oe),
    .current_loop_fault_n_o(), .current_loop_fault_n_oe(cl_oe),
    .voltage_short_fault_n_o(), .voltage_short_fault_n_oe(vs_oe),
    .over_temp_fault_n_o(), .over_temp_fault_n_oe(ot_oe), .range_sel(rsel),
    .current_mode(cmode), .range_valid(rvalid), .outputs_enabled(output_enable_bit),
    .clear_active(clr_act), .clear_to_mid(clr_mid));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // f holds clear level, enable, resistor, soft clear, reset
  function automatic logic [23:0] ww(input logic [3:0] r,
    input logic [4:0] f);
    return {ADDR, 2'b00, r, f, 2'b00, 8'h00};
  endfunction
  task wr(input logic [3:0] r, input logic [4:0] f);
    i_odc_host.xfer(16, ww(r, f), rd, seen);
  endtask
  task wrc(input logic [3:0] r, input logic [4:0] f, input logic flip);
    logic [23:0] w;
    w = ww(r, f);
    w[7:0] = crc8(w[23:8]) ^ {7'h00, flip};
    i_odc_host.xfer(24, w, rd, seen);
  endtask
  task rdw(input logic [2:0] a);
    i_odc_host.xfer(20, {a, 1'b1, 20'h00000}, rd, seen);
  endtask
  task endt(input string s);
    $display("test %s done", s);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk(rsel, ODC_I_4_20);
    chk(output_enable_bit, 1'b0);
    chk(sdo_oe, 1'b0);
    endt("reset");
    for (int i = 0; i < 7; i++) begin
      wr(codes[i], 5'h04);
      chk(rsel, exp_r[i]);
      chk(cmode, i > 3);
      chk(rvalid, 1'b1);
    end
    wr(4'h0, 5'h00);
    chk(rsel, ODC_I_4_20);
    wr(4'he, 5'h00);
    chk(rsel, ODC_V_0_40);
    chk(cmode, 1'b0);
    wr(4'hf, 5'h00);
    chk(rsel, ODC_V_0_44);
    endt("decode");
    wr(4'hf, 5'h1c);
    chk(output_enable_bit, 1'b1);
    chk(clr_mid, 1'b1);
    otemp <= 1'b1;
    lopen <= 1'b1;
    vshort <= 1'b1;
    repeat (6) @(posedge clk);
    chk(fault_oe, 1'b1);
    rdw(ADDR);
    chk(seen, 1'b1);
    chk(rd, {ADDR, 2'b10, 4'hf, 3'h7, 4'h7});
    chk(sdo_oe, 1'b0);
    otemp <= 1'b0;
    lopen <= 1'b0;
    vshort <= 1'b0;
    repeat (6) @(posedge clk);
    chk(fault_oe, 1'b0);
    rdw(ADDR ^ 3'h1);
    chk(seen, 1'b0);
    i_odc_host.xfer(16, ww(4'h5, 5'h04) ^ 24'h200000, rd, seen);
    chk(rsel, ODC_I_0_245);
    endt("readback");
    wrc(4'h5, 5'h04, 1'b0);
    chk(rsel, ODC_V_0_5);
    wrc(4'h6, 5'h04, 1'b1);
    chk(rsel, ODC_V_0_5);
    chk(fault_oe, 1'b1);
    rdw(ADDR);
    chk(rd, {ADDR, 2'b10, 4'h5, 3'h1, 4'h8});
    chk(fault_oe, 1'b0);
    rdw(ADDR);
    chk(rd[3:0], 4'h0);
    endt("crc");
    wr(4'h5, 5'h06);
    chk(clr_act, 1'b1);
    chk(clr_mid, 1'b0);
    clrlvl <= 1'b1;
    repeat (6) @(posedge clk);
    chk(clr_mid, 1'b1);
    clrlvl <= 1'b0;
    wr(4'h5, 5'h04);
    chk(clr_act, 1'b0);
    clrp <= 1'b1;
    repeat (6) @(posedge clk);
    chk(clr_act, 1'b1);
    clrp <= 1'b0;
    wr(4'h5, 5'h0d);
    chk(rsel, ODC_I_4_20);
    chk(output_enable_bit, 1'b0);
    endt("clear");
    hw <= 1'b1;
    rpins <= 4'h5;
    sense_resistor_select_p <= 1'b1;
    lopen <= 1'b1;
    oenp <= 1'b1;
    repeat (8) @(posedge clk);
    chk(rsel, ODC_V_0_5);
    chk(cl_oe, 1'b1);
    chk(ot_oe, 1'b0);
    chk(output_enable_bit, 1'b1);
    otemp <= 1'b1;
    vshort <= 1'b1;
    repeat (6) @(posedge clk);
    chk(ot_oe, 1'b1);
    chk(vs_oe, 1'b1);
    chk(fault_oe, 1'b0);
    rdw(ADDR);
    chk(seen, 1'b0);
    endt("pins");
    test_done;
  end
  initial begin
    #1000000;
    bad_count++;
    test_done;
  end
endmodule
